// >>> verilog/asw_ctrl.sv
// Host controller that performs single write and read cycles on an asynchronous static RAM.
// Assumes the RAM pins are wired directly; the bench resolves the data bus from the enables.
module asw_ctrl
   import asw_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   output logic [ADDR_W-1:0] mem_addr,
   output logic mem_cs_n,
   output logic mem_we_n,
   output logic mem_oe_n,
   output logic [DATA_W-1:0] mem_dq_o,
   output logic mem_dq_oe,
   input wire logic [DATA_W-1:0] mem_dq_i
);
   asw_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [DATA_W-1:0] dq_s1;
   logic [DATA_W-1:0] dq_s2;
   logic [DATA_W-1:0] dq_s3;

   // Every wait state counts up the same way, so the wrap width lives in one place.
   function automatic logic [CNT_W-1:0] cnt_next(input logic [CNT_W-1:0] value);
      return value + 1'b1;
   endfunction : cnt_next

   // The counter is narrow on purpose; a slower grade or a faster clock must widen it.
   if (WP_CYC >= (1 << CNT_W) || WC_CYC >= (1 << CNT_W)) begin : g_bad_wr
      $error("Counter too narrow for the write pulse.");
   end
   if (AA_CYC + 3 >= (1 << CNT_W) || OHZ_CYC >= (1 << CNT_W)) begin : g_bad_rd
      $error("Counter too narrow for the read access.");
   end
   if (WP_CYC < 1 || WR_CYC < 1 || OHZ_CYC < 1) begin : g_bad_min
      $error("Timing counts must be at least one cycle.");
   end

   // Three stages so the stable value is taken once the last two agree.
   always_ff @(posedge sys_clk) begin
      dq_s1 <= mem_dq_i;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state <= asw_idle;
         cnt <= '0;
         req_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= '0;
         mem_addr <= '0;
         mem_cs_n <= 1'b1;
         mem_we_n <= 1'b1;
         mem_oe_n <= 1'b1;
         mem_dq_o <= '0;
         mem_dq_oe <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         case (state)
            asw_idle: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  // Outside reset, address only moves here, with the write strobe high.
                  mem_addr <= req_addr; // RULE1
                  mem_cs_n <= 1'b0;
                  mem_oe_n <= 1'b1; // RULE13
                  mem_dq_o <= req_wdata;
                  cnt <= '0;
                  state <= req_write ? asw_wsetup : asw_rsetup;
               end
            end
            asw_wsetup: begin
               // Strobe falls first; data is driven one cycle later, never before.
               mem_we_n <= 1'b0; // RULE4
               state <= asw_wpulse;
            end
            asw_wpulse: begin
               mem_dq_oe <= 1'b1; // RULE2
               cnt <= cnt_next(cnt);
               if (cnt == CNT_W'(WP_CYC)) begin
                  // Strobe and select rise together; data is held this edge.
                  mem_we_n <= 1'b1; // RULE2
                  mem_cs_n <= 1'b1;
                  cnt <= '0;
                  state <= asw_wrec;
               end
            end
            asw_wrec: begin
               mem_dq_oe <= 1'b0; // RULE6
               cnt <= cnt_next(cnt);
               if (cnt_next(cnt) >= CNT_W'(WR_CYC)) begin // RULE3
                  state <= asw_idle;
               end
            end
            asw_rsetup: begin
               mem_oe_n <= 1'b0;
               state <= asw_rwait;
            end
            asw_rwait: begin
               cnt <= cnt_next(cnt);
               // Access time plus the input synchroniser depth.
               if (cnt == CNT_W'(AA_CYC + 3)) begin
                  // A settling bus is never handed on; a bus that never settles stalls here.
                  if (dq_s2 == dq_s3) begin
                     rd_data <= dq_s3;
                     rd_valid <= 1'b1;
                     mem_oe_n <= 1'b1;
                     mem_cs_n <= 1'b1;
                     cnt <= '0;
                     state <= asw_rend;
                  end else begin
                     cnt <= cnt;
                  end
               end
            end
            asw_rend: begin
               // Give the memory time to release the bus before any write drives it.
               cnt <= cnt_next(cnt);
               if (cnt_next(cnt) >= CNT_W'(OHZ_CYC)) begin
                  state <= asw_idle;
               end
            end
            default: state <= asw_idle;
         endcase
      end
   end

   property p_addr_stable;
      @(posedge sys_clk) disable iff (!nrst) !mem_we_n |=> $stable(mem_addr);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("Address moved during write."); // RULE1

   property p_drive_in_overlap;
      @(posedge sys_clk) disable iff (!nrst) mem_dq_oe && !mem_we_n |-> !mem_cs_n;
   endproperty
   a_drive_in_overlap: assert property (p_drive_in_overlap) else $error("Data without select."); // RULE2

   property p_recovery;
      @(posedge sys_clk) disable iff (!nrst) $rose(mem_we_n) |-> mem_cs_n ##1 mem_cs_n;
   endproperty
   a_recovery: assert property (p_recovery) else $error("Recovery too short."); // RULE3

   property p_no_early_drive;
      @(posedge sys_clk) disable iff (!nrst) $fell(mem_we_n) |-> !mem_dq_oe;
   endproperty
   a_no_early_drive: assert property (p_no_early_drive) else $error("Data driven early."); // RULE4

   property p_release;
      @(posedge sys_clk) disable iff (!nrst) $rose(mem_we_n) |=> !mem_dq_oe;
   endproperty
   a_release: assert property (p_release) else $error("Bus not released."); // RULE6

   property p_oe_write;
      @(posedge sys_clk) disable iff (!nrst) !mem_we_n |-> mem_oe_n;
   endproperty
   a_oe_write: assert property (p_oe_write) else $error("Output enable low in write."); // RULE13

   property p_no_fight;
      @(posedge sys_clk) disable iff (!nrst) mem_dq_oe |-> mem_oe_n;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("Bus contention."); // RULE12

   property p_pulse_len;
      @(posedge sys_clk) disable iff (!nrst) $fell(mem_we_n) |-> !mem_we_n [*4];
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("Write pulse short."); // RULE2

   // A reset may cut a cycle short, so a_addr_change and a_data_hold skip the edge after it.
   property p_addr_change;
      @(posedge sys_clk) disable iff (!nrst)
         $changed(mem_addr) && $past(nrst) |-> mem_we_n && $past(mem_we_n);
   endproperty
   a_addr_change: assert property (p_addr_change) else $error("Address moved near strobe."); // RULE1

   property p_ready_idle;
      @(posedge sys_clk) disable iff (!nrst) req_ready |-> mem_cs_n && mem_we_n && mem_oe_n && !mem_dq_oe;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("Ready before recovery."); // RULE3

   property p_read_no_drive;
      @(posedge sys_clk) disable iff (!nrst) !mem_oe_n |-> !mem_dq_oe && mem_we_n;
   endproperty
   a_read_no_drive: assert property (p_read_no_drive) else $error("Driving during read."); // RULE6

   property p_oe_fall;
      @(posedge sys_clk) disable iff (!nrst) $fell(mem_oe_n) |-> !mem_cs_n && mem_we_n;
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("Output enable outside a read."); // RULE13

   property p_data_hold;
      @(posedge sys_clk) disable iff (!nrst) $rose(mem_we_n) && $past(nrst) |-> mem_dq_oe;
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("Data not held at strobe end."); // RULE2

   property p_data_stable;
      @(posedge sys_clk) disable iff (!nrst) $changed(mem_dq_o) |-> mem_we_n;
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("Data moved in write."); // RULE2

   property p_select_hold;
      @(posedge sys_clk) disable iff (!nrst) !mem_we_n |-> !mem_cs_n;
   endproperty
   a_select_hold: assert property (p_select_hold) else $error("Strobe without select."); // RULE2

   property p_rd_pulse;
      @(posedge sys_clk) disable iff (!nrst) rd_valid |=> !rd_valid;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("Read valid too long."); // RULE8

   property p_read_len;
      @(posedge sys_clk) disable iff (!nrst) $fell(mem_oe_n) |-> !mem_oe_n [*8];
   endproperty
   a_read_len: assert property (p_read_len) else $error("Read access too short."); // RULE8

   property p_cs_end;
      @(posedge sys_clk) disable iff (!nrst) $rose(mem_cs_n) |-> mem_we_n && mem_oe_n;
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("Cycle ended with strobe low."); // RULE3
endmodule : asw_ctrl

// >>> pkg/asw_pkg.sv
// Constants and state type for the host-side controller of an asynchronous 32K x 8 static RAM.
// Assumes a single 50 MHz clock and a synchronous active-low reset.
// How it works
// RULE1: The controller keeps the write strobe high whenever the address lines change; a reset in a write clears the address on the edge the strobe rises.
// RULE2: The memory stores data only while chip select and write strobe are both low.
// RULE3: After the first of chip select or write strobe rises, the controller waits the write recovery interval before the next cycle.
// RULE4: Before the write strobe falls the controller does not drive the data pins.
// RULE5: When chip select falls with or after the write strobe the memory keeps its outputs off.
// RULE6: After a write with chip select still low, the controller releases the data pins for the memory.
// RULE7: With output enable low, the first data shown after a write equals the value just written.
// RULE8: When the address moves on, the memory shows the contents of the new address.
// RULE9: The array holds 32768 words of 8 bits on one shared bidirectional data bus.
// RULE10: With chip select high the memory is in standby with its data pins off.
// RULE11: With chip select low a low write strobe writes and a high one reads, driving only when output enable is low.
// RULE12: Output enable gates the memory drivers; when it is high the data pins are off.
// RULE13: The controller keeps output enable high during write cycles.
package asw_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CLK_NS = 20;
   // Slower speed grade figures are used so either grade is served.
   localparam int T_WC_NS = 100;
   localparam int T_WP_NS = 70;
   localparam int T_DW_NS = 40;
   localparam int T_WR_NS = 5;
   localparam int T_AA_NS = 100;
   localparam int T_OE_NS = 50;
   localparam int T_OHZ_NS = 35;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
   localparam int AA_CYC = (T_AA_NS + CLK_NS - 1) / CLK_NS;
   localparam int OHZ_CYC = (T_OHZ_NS + CLK_NS - 1) / CLK_NS;
   localparam int WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
   typedef enum logic [2:0] {
      asw_idle, asw_wsetup, asw_wpulse, asw_wrec, asw_rsetup, asw_rwait, asw_rend
   } asw_state_t;
endpackage : asw_pkg

// >>> tb/asw_sram_model.sv
// Behavioural asynchronous 32K x 8 static RAM on the far side of the controller.
// Assumes the bench resolves the shared data bus and feeds it back on bus.
module asw_sram_model
   import asw_pkg::*;
#(
   parameter int ACC_NS = 90
)
(
   input wire logic [ADDR_W-1:0] addr,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [DATA_W-1:0] bus,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [0:32767];
   logic [DATA_W-1:0] last = 8'h00;
   assign dq_oe = !cs_n && we_n && !oe_n;
   // Level write, so the last bus value of the overlap is the one kept.
   always @* begin
      if (!cs_n && !we_n) begin
         mem[addr] = bus;
      end
   end
   always @* begin
      if (dq_oe) begin
         last = mem[addr];
      end
   end
   // A released bus shows the inverse of the last value, never a friendly copy.
   assign #(ACC_NS) dq_o = dq_oe ? mem[addr] : ~last;
endmodule : asw_sram_model

// >>> tb/asw_ctrl_test.sv
// Self-checking bench for the static RAM host controller.
// Assumes the controller and the RAM model share one bus resolved here.
module asw_ctrl_test;
   import asw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic [ADDR_W-1:0] req_addr = 15'h0000, mem_addr, prev_addr;
   logic [DATA_W-1:0] req_wdata = 8'h00, rd_data, mem_dq_o, sram_dq, bus;
   logic req_ready, rd_valid, mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe, sram_oe;
   int n_fail = 0, total_checks = 0, cycles = 0;
   always #10 sys_clk = ~sys_clk;
   assign bus = mem_dq_oe ? mem_dq_o : sram_dq;
   asw_ctrl asw_ctrl_i (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .mem_addr(mem_addr),
      .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_o(mem_dq_o),
      .mem_dq_oe(mem_dq_oe), .mem_dq_i(bus));
   asw_sram_model asw_sram_model_i (.addr(mem_addr), .cs_n(mem_cs_n), .we_n(mem_we_n),
      .oe_n(mem_oe_n), .bus(bus), .dq_o(sram_dq), .dq_oe(sram_oe));
   task automatic stop_test;
      if (n_fail == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t read %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic ok, input string what);
      total_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask : chk_bit
   // Wire checks use pre-edge values, so design updates at the edge cannot race them.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         stop_test();
      end
      if (nrst) begin
         chk_bit(!(mem_dq_oe && sram_oe), "bus contention");
         chk_bit(mem_we_n || mem_oe_n, "output enable low in write");
         chk_bit(mem_we_n || mem_addr === prev_addr, "address moved in write");
         chk_bit(mem_we_n || !mem_cs_n, "strobe without select");
      end
      prev_addr = mem_addr;
   end
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      while (req_ready !== 1'b1) @(negedge sys_clk);
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      @(negedge sys_clk);
      req_valid = 1'b0;
   endtask : issue
   task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      int n;
      n = 0;
      issue(1'b0, a, 8'h00);
      while (rd_valid !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      chk_bit(rd_valid === 1'b1, "read not answered");
      chk_byte(rd_data, exp);
   endtask : do_read
   task automatic t_write_read;
      issue(1'b1, 15'h0000, 8'hA5);
      do_read(15'h0000, 8'hA5);
   endtask : t_write_read
   task automatic t_back_to_back;
      issue(1'b1, 15'h7FFF, 8'h3C);
      issue(1'b1, 15'h0001, 8'hC3);
      do_read(15'h7FFF, 8'h3C);
      do_read(15'h0001, 8'hC3);
   endtask : t_back_to_back
   task automatic t_overwrite;
      issue(1'b1, 15'h0001, 8'h5A);
      do_read(15'h0001, 8'h5A);
      do_read(15'h0000, 8'hA5);
   endtask : t_overwrite
   task automatic t_mid_reset;
      issue(1'b1, 15'h0002, 8'h77);
      repeat (2) @(negedge sys_clk);
      nrst = 1'b0;
      @(negedge sys_clk);
      chk_bit(mem_cs_n && mem_we_n && mem_oe_n && !mem_dq_oe && !req_ready, "reset");
      nrst = 1'b1;
      do_read(15'h0001, 8'h5A);
   endtask : t_mid_reset
   initial begin
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      t_write_read();
      t_back_to_back();
      t_overwrite();
      t_mid_reset();
      stop_test();
   end
endmodule : asw_ctrl_test
